/* File: pkg/sbbs_consts.svh */
// Constants of the serial baud, break and status block.
// Assumes inclusion by bare name from the package and the design file.
`ifndef SBBS_CONSTS_SVH
`define SBBS_CONSTS_SVH

// ***************************************************************
// Register offsets
// ***************************************************************
`define SBBS_OFS_STATUS_TWO   8'h16
`define SBBS_OFS_DATA_BUF     8'h18
`define SBBS_OFS_BAUD_RATE    8'h19
`define SBBS_OFS_PRESCALER    8'h1a
`define SBBS_OFS_INT_STATUS   8'h1b
`define SBBS_OFS_INT_MASK     8'h1c

// ***************************************************************
// Field positions
// ***************************************************************
`define SBBS_BIT_RPF          0
`define SBBS_BIT_BKF          1
`define SBBS_BIT_LIN_BREAK_SEND_ENABLE         7
`define SBBS_BIT_LIN_BREAK_DETECT_ENABLE         6
`define SBBS_SCP_HI           5
`define SBBS_SCP_LO           4
`define SBBS_SCR_HI           2
`define SBBS_SCR_LO           0
`define SBBS_PDS_HI           7
`define SBBS_PDS_LO           5
`define SBBS_INS_HI           4
`define SBBS_INS_LO           0
`define SBBS_IRQ_RX_LOAD      0
`define SBBS_IRQ_TX_BRK_DONE  1
`define SBBS_IRQ_IDLE         2

// ***************************************************************
// Reset values and timing counts
// ***************************************************************
`define SBBS_RST_CTRL         8'h00
`define SBBS_BAUD_RW_MASK     8'hf7
`define SBBS_INT_MASK_BITS    8'h07
`define SBBS_PRE_DIV_1        4'h0
`define SBBS_PRE_DIV_3        4'h2
`define SBBS_PRE_DIV_4        4'h3
`define SBBS_PRE_DIV_13       4'hc
`define SBBS_RT_PER_BIT       9'h010
`define SBBS_CLK_PER_RT       2'h3
`define SBBS_RT_LAST          4'hf
`define SBBS_BRK_NORM_BITS    9'h00a
`define SBBS_BRK_LIN_BREAK_DETECT_ENABLE_BITS    9'h00b
`define SBBS_BRK_LIN_BREAK_SEND_ENABLE_BITS    9'h00d

`endif

/* File: pkg/sbbs_pkg.sv */
// Types shared by the serial baud, break and status block.
// Assumes the constants header is on the include path.
`include "sbbs_consts.svh"

package sbbs_pkg;

   // Events from the receive shifter
   typedef struct packed {
      logic       rt1_low;
      logic       false_start;
      logic       idle_det;
      logic       char_done;
      logic [7:0] rx_byte;
   } sbbs_rx_ev_s;

   // Pulses toward status register 1 and control register 3
   typedef struct packed {
      logic framing_set;
      logic full_set;
      logic ninth_clear;
   } sbbs_brk_out_s;

   typedef enum logic [1:0] {
      SBBS_TX_IDLE,
      SBBS_TX_BREAK,
      SBBS_TX_MARK
   } sbbs_tx_state_e;

endpackage : sbbs_pkg

/* File: rtl/sbbs_top.sv */
// Break and reception flags, data buffer, LIN break options, baud generator.
// Assumes the receive and transmit shifters sit outside and run on rt_tick.
//
// How it works
// R1: A detected break sets the break flag, framing error and receive full.
// R2: In nine-bit mode a detected break clears the ninth received bit.
// R3: Break flag never interrupts; status read then data read clears it.
// R4: After clearing, the break flag rearms only once the line returns high.
// R5: Reception flag sets on a low sample in the first start search slot.
// R6: Reception flag clears on a false start or an idle character.
// R7: Data address reads received byte, writes transmit byte; reset keeps contents.
// R8: Software avoids read-modify-write on the data buffer address.
// R9: LIN send makes breaks 13 or 14 bits long, else normal length.
// R10: LIN detect reports breaks only after 11 or 12 low bits.
// R11: Software still checks break length; the filter only rejects low runs under 11 or 12 bits.
// R12: Pre-divider select picks 1, 3, 4 or 13.
// R13: Rate divider select n divides by two to the n.
// R14: Fine prescaler select 000 bypasses, otherwise divides by 2 to 8.
// R15: Software does not toggle prescaler bypass while the module is enabled.
// R16: Insertion count N adds N input clocks per 32 prescaler outputs.
// R17: Bit rate is bus clock over 64, pre-divisor, rate divisor, prescaler.
// R18: In bypass the prescaler divides by one and insertion is ignored.
`timescale 1ns/10ps
`include "sbbs_consts.svh"

module sbbs_top (
   input  wire logic                  core_clk,
   input  wire logic                  reset_n,
   input  wire logic [7:0]            reg_addr,
   input  wire logic [7:0]            reg_wdata,
   input  wire logic                  reg_wr,
   input  wire logic                  reg_rd,
   output logic      [7:0]            reg_rdata,
   input  wire logic                  serial_module_enable,
   input  wire logic                  char_len_sel,
   input  wire logic                  nine_bit_mode,
   input  wire logic                  rx_pin,
   input  wire sbbs_pkg::sbbs_rx_ev_s rx_ev,
   input  wire logic                  tx_break_req,
   output logic                       tx_break_line,
   output logic                       tx_break_done,
   output sbbs_pkg::sbbs_brk_out_s    brk_out,
   output logic      [7:0]            tx_byte,
   output logic                       tx_load,
   output logic                       rt_tick,
   output logic                       bit_tick,
   output logic                       irq
);

   // ***************************************************************
   // Registers and decode
   // ***************************************************************
   logic [7:0] baud_rate_control;
   logic [7:0] baud_prescaler_control;
   logic [7:0] serial_data_buffer;
   logic [7:0] int_status;
   logic [7:0] int_mask;
   logic       break_detected_flag;
   logic       reception_active_flag;
   logic       bkf_clr_armed;
   logic       brk_armed;
   logic       brk_event;
   logic [8:0] low_cnt;
   logic [8:0] rx_brk_target;
   logic [7:0] receive_status_two;
   logic       lin_break_send_enable;
   logic       lin_break_detect_enable;
   logic [1:0] rate_pre_divider_select;
   logic [2:0] rate_divider_select;
   logic [2:0] fine_prescaler_select;
   logic [4:0] clock_insertion_count;
   logic       wr_data;
   logic       rd_data;
   logic       rd_status_two;
   logic [7:0] next_rdata;
   logic [7:0] irq_events;

   assign lin_break_send_enable   = baud_rate_control[`SBBS_BIT_LIN_BREAK_SEND_ENABLE];
   assign lin_break_detect_enable = baud_rate_control[`SBBS_BIT_LIN_BREAK_DETECT_ENABLE];
   assign rate_pre_divider_select = baud_rate_control[`SBBS_SCP_HI:`SBBS_SCP_LO];
   assign rate_divider_select     = baud_rate_control[`SBBS_SCR_HI:`SBBS_SCR_LO];
   assign fine_prescaler_select   = baud_prescaler_control[`SBBS_PDS_HI:`SBBS_PDS_LO];
   assign clock_insertion_count   = baud_prescaler_control[`SBBS_INS_HI:`SBBS_INS_LO];

   assign wr_data       = reg_wr && (reg_addr == `SBBS_OFS_DATA_BUF);
   assign rd_data       = reg_rd && (reg_addr == `SBBS_OFS_DATA_BUF);
   assign rd_status_two = reg_rd && (reg_addr == `SBBS_OFS_STATUS_TWO);

   always_comb
   begin
      receive_status_two = 8'h00;
      receive_status_two[`SBBS_BIT_BKF] = break_detected_flag;
      receive_status_two[`SBBS_BIT_RPF] = reception_active_flag;
   end

   // R12 R13 R14 R16 control fields cleared by reset
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         baud_rate_control      <= `SBBS_RST_CTRL;
         baud_prescaler_control <= `SBBS_RST_CTRL;
         int_mask               <= `SBBS_RST_CTRL;
      end
      else if (reg_wr)
      begin
         if (reg_addr == `SBBS_OFS_BAUD_RATE)
            baud_rate_control <= reg_wdata & `SBBS_BAUD_RW_MASK;
         if (reg_addr == `SBBS_OFS_PRESCALER)
            baud_prescaler_control <= reg_wdata;
         if (reg_addr == `SBBS_OFS_INT_MASK)
            int_mask <= reg_wdata & `SBBS_INT_MASK_BITS;
      end
   end

   always_comb
   begin
      next_rdata = 8'h00;
      if (reg_rd)
      begin
         unique case (reg_addr)
            `SBBS_OFS_STATUS_TWO: next_rdata = receive_status_two;
            `SBBS_OFS_DATA_BUF:   next_rdata = serial_data_buffer;
            `SBBS_OFS_BAUD_RATE:  next_rdata = baud_rate_control;
            `SBBS_OFS_PRESCALER:  next_rdata = baud_prescaler_control;
            `SBBS_OFS_INT_STATUS: next_rdata = int_status;
            `SBBS_OFS_INT_MASK:   next_rdata = int_mask;
            default:              next_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
         reg_rdata <= 8'h00;
      else
         reg_rdata <= next_rdata;
   end

   // ***************************************************************
   // Data buffer
   // ***************************************************************
   // R7 buffer contents survive reset
   always_ff @(posedge core_clk)
   begin
      if (rx_ev.char_done)
         serial_data_buffer <= rx_ev.rx_byte;
      if (wr_data)
         tx_byte <= reg_wdata;
   end

   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
         tx_load <= 1'b0;
      else
         tx_load <= wr_data;
   end

   // ***************************************************************
   // Baud generator
   // ***************************************************************
   logic [3:0] pd_cnt;
   logic [4:0] pd_frame;
   logic [3:0] pd_limit;
   logic       pd_bypass;
   logic       pd_tick;
   logic [3:0] bpd_cnt;
   logic [3:0] bpd_last;
   logic       bpd_tick;
   logic [6:0] bd_cnt;
   logic [6:0] bd_last;
   logic       bd_tick;
   logic [1:0] q_cnt;
   logic [3:0] rt_phase;
   logic       rt_pulse;

   assign pd_bypass = (fine_prescaler_select == 3'h0);
   // R16 first N outputs of each frame take one extra clock
   assign pd_limit  = {1'b0, fine_prescaler_select}
                    + ((pd_frame < clock_insertion_count) ? 4'h1 : 4'h0);
   // R14 R18 bypass ticks every clock and ignores insertion
   assign pd_tick   = serial_module_enable && (pd_bypass || (pd_cnt == pd_limit));

   // R12 pre-divisor choice
   always_comb
   begin
      unique case (rate_pre_divider_select)
         2'h0: bpd_last = `SBBS_PRE_DIV_1;
         2'h1: bpd_last = `SBBS_PRE_DIV_3;
         2'h2: bpd_last = `SBBS_PRE_DIV_4;
         2'h3: bpd_last = `SBBS_PRE_DIV_13;
      endcase
   end
   assign bpd_tick = pd_tick && (bpd_cnt == bpd_last);

   // R13 power of two divider
   assign bd_last = 7'((8'h01 << rate_divider_select) - 8'h01);
   assign bd_tick = bpd_tick && (bd_cnt == bd_last);
   // R17 four clocks per sample, sixteen samples per bit
   assign rt_pulse = bd_tick && (q_cnt == `SBBS_CLK_PER_RT);

   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         pd_cnt   <= 4'h0;
         pd_frame <= 5'h00;
      end
      else if (!serial_module_enable)
      begin
         pd_cnt   <= 4'h0;
         pd_frame <= 5'h00;
      end
      else if (pd_tick)
      begin
         pd_cnt   <= 4'h0;
         pd_frame <= pd_frame + 5'h01;
      end
      else
         pd_cnt <= pd_cnt + 4'h1;
   end

   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         bpd_cnt  <= 4'h0;
         bd_cnt   <= 7'h00;
         q_cnt    <= 2'h0;
         rt_phase <= 4'h0;
      end
      else if (!serial_module_enable)
      begin
         bpd_cnt  <= 4'h0;
         bd_cnt   <= 7'h00;
         q_cnt    <= 2'h0;
         rt_phase <= 4'h0;
      end
      else
      begin
         if (pd_tick)
            bpd_cnt <= bpd_tick ? 4'h0 : bpd_cnt + 4'h1;
         if (bpd_tick)
            bd_cnt <= bd_tick ? 7'h00 : bd_cnt + 7'h01;
         if (bd_tick)
            q_cnt <= q_cnt + 2'h1;
         if (rt_pulse)
            rt_phase <= rt_phase + 4'h1;
      end
   end

   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rt_tick  <= 1'b0;
         bit_tick <= 1'b0;
      end
      else
      begin
         rt_tick  <= rt_pulse;
         bit_tick <= rt_pulse && (rt_phase == `SBBS_RT_LAST);
      end
   end

   // ***************************************************************
   // Break detection
   // ***************************************************************
   // R10 LIN detect lengthens the low run needed by one bit
   assign rx_brk_target = 9'((lin_break_detect_enable ? `SBBS_BRK_LIN_BREAK_DETECT_ENABLE_BITS
                                                       : `SBBS_BRK_NORM_BITS)
                             + {8'h00, char_len_sel}) * `SBBS_RT_PER_BIT;
   assign brk_event = brk_armed && rt_tick && !rx_pin && ((low_cnt + 9'h001) == rx_brk_target);

   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
         low_cnt <= 9'h000;
      else if (rx_pin)
         low_cnt <= 9'h000;
      else if (rt_tick && (low_cnt != rx_brk_target))
         low_cnt <= low_cnt + 9'h001;
   end

   // R4 rearm only after the line is seen high
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
         brk_armed <= 1'b1;
      else if (brk_event)
         brk_armed <= 1'b0;
      else if (rx_pin)
         brk_armed <= 1'b1;
   end

   // R3 clear needs status read with flag set, then data read; set wins
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         break_detected_flag <= 1'b0;
         bkf_clr_armed       <= 1'b0;
      end
      else
      begin
         if (brk_event)
            break_detected_flag <= 1'b1;
         else if (rd_data && bkf_clr_armed)
            break_detected_flag <= 1'b0;
         if (rd_status_two && break_detected_flag)
            bkf_clr_armed <= 1'b1;
         else if (rd_data || !break_detected_flag)
            bkf_clr_armed <= 1'b0;
      end
   end

   // R1 R2 side effects of a break
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
         brk_out <= '0;
      else
      begin
         brk_out.framing_set <= brk_event;
         brk_out.full_set    <= brk_event;
         brk_out.ninth_clear <= brk_event && nine_bit_mode;
      end
   end

   // ***************************************************************
   // Reception in progress
   // ***************************************************************
   // R5 R6 set on first slot low, cleared on false start or idle
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
         reception_active_flag <= 1'b0;
      else if (rx_ev.rt1_low)
         reception_active_flag <= 1'b1;
      else if (rx_ev.false_start || rx_ev.idle_det)
         reception_active_flag <= 1'b0;
   end

   // ***************************************************************
   // Break transmit
   // ***************************************************************
   sbbs_pkg::sbbs_tx_state_e tx_state;
   logic [8:0]               tx_bits;
   logic [8:0]               tx_brk_len;

   // R9 LIN send gives 13 or 14 bits, else 10 or 11
   assign tx_brk_len = (lin_break_send_enable ? `SBBS_BRK_LIN_BREAK_SEND_ENABLE_BITS : `SBBS_BRK_NORM_BITS)
                     + {8'h00, char_len_sel};

   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         tx_state      <= sbbs_pkg::SBBS_TX_IDLE;
         tx_bits       <= 9'h000;
         tx_break_line <= 1'b1;
         tx_break_done <= 1'b0;
      end
      else
      begin
         tx_break_done <= 1'b0;
         unique case (tx_state)
            sbbs_pkg::SBBS_TX_IDLE:
               if (tx_break_req && serial_module_enable)
               begin
                  tx_state      <= sbbs_pkg::SBBS_TX_BREAK;
                  tx_bits       <= 9'h000;
                  tx_break_line <= 1'b0;
               end
            sbbs_pkg::SBBS_TX_BREAK:
               if (bit_tick)
               begin
                  if (tx_bits + 9'h001 == tx_brk_len)
                  begin
                     tx_state      <= sbbs_pkg::SBBS_TX_MARK;
                     tx_break_line <= 1'b1;
                  end
                  tx_bits <= tx_bits + 9'h001;
               end
            sbbs_pkg::SBBS_TX_MARK:
               if (bit_tick)
               begin
                  tx_state      <= sbbs_pkg::SBBS_TX_IDLE;
                  tx_break_done <= 1'b1;
               end
         endcase
      end
   end

   // ***************************************************************
   // Interrupts
   // ***************************************************************
   always_comb
   begin
      irq_events = 8'h00;
      irq_events[`SBBS_IRQ_RX_LOAD]     = rx_ev.char_done;
      irq_events[`SBBS_IRQ_TX_BRK_DONE] = tx_break_done;
      irq_events[`SBBS_IRQ_IDLE]        = rx_ev.idle_det;
   end

   // Write one to clear, a new event in the same cycle wins
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
         int_status <= 8'h00;
      else if (reg_wr && (reg_addr == `SBBS_OFS_INT_STATUS))
         int_status <= (int_status & ~reg_wdata) | irq_events;
      else
         int_status <= int_status | irq_events;
   end

   assign irq = |(int_status & int_mask);

   // ***************************************************************
   // Assertions
   // ***************************************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);

   bkf_set_a: assert property (brk_event |=> break_detected_flag) // R1
      else $error("break flag not set by a break");
   brk_side_a: assert property (brk_event |=> brk_out.framing_set && brk_out.full_set) // R1
      else $error("framing or full not pulsed on break");
   ninth_clear_a: assert property (brk_event && nine_bit_mode |=> brk_out.ninth_clear) // R2
      else $error("ninth bit not cleared on break");
   bkf_clear_a: assert property (rd_data && bkf_clr_armed && !brk_event
                                 |=> !break_detected_flag) // R3
      else $error("break flag not cleared by sequence");
   bkf_hold_a: assert property (break_detected_flag && !bkf_clr_armed
                                |=> break_detected_flag) // R3
      else $error("break flag cleared without status read");
   rearm_wait_a: assert property (!brk_armed && !rx_pin |=> !brk_event) // R4
      else $error("break seen again without line high");
   rpf_set_a: assert property (rx_ev.rt1_low |=> reception_active_flag) // R5
      else $error("reception flag not set");
   rpf_clear_a: assert property ((rx_ev.false_start || rx_ev.idle_det) && !rx_ev.rt1_low
                                 |=> !reception_active_flag) // R6
      else $error("reception flag not cleared");
   data_read_a: assert property (rd_data |=> reg_rdata == $past(serial_data_buffer)) // R7
      else $error("data read returns wrong byte");
   tx_len_a: assert property (tx_state == sbbs_pkg::SBBS_TX_BREAK
                              |-> tx_bits < tx_brk_len) // R9
      else $error("transmitted break too long");
   lin_len_a: assert property (brk_event |-> low_cnt == rx_brk_target - 9'h001) // R10
      else $error("break reported at wrong length");
   bypass_tick_a: assert property (serial_module_enable && pd_bypass |-> pd_tick) // R18
      else $error("bypass prescaler not every clock");
   chain_a: assert property (rt_pulse |-> bd_tick && bpd_tick && pd_tick) // R17
      else $error("sample tick outside divider chain");

   brk_cover_c: cover property (brk_event);
   tx_brk_cover_c: cover property (tx_break_done);
   false_start_c: cover property (rx_ev.rt1_low ##[1:64] rx_ev.false_start);

endmodule : sbbs_top

/* File: testbench/sbbs_line_node.sv */
// Remote node model on the receive line.
// Assumes rt_tick of the block paces the dominant run; the line idles high.
`timescale 1ns/10ps

module sbbs_line_node (
   input  wire logic        core_clk,
   input  wire logic        rt_tick,
   input  wire logic        go,
   input  wire logic [11:0] low_rt,
   output logic             rx_pin,
   output logic             busy
);
   logic [11:0] cnt;

   initial busy = 1'b0;

   always @(posedge core_clk)
   begin
      if (go)
      begin
         cnt  <= low_rt;
         busy <= 1'b1;
      end
      else if (busy && rt_tick)
      begin
         cnt  <= cnt - 12'h001;
         busy <= (cnt != 12'h001);
      end
   end

   // Released line returns to its pull-up level
   assign rx_pin = !busy;
endmodule : sbbs_line_node

/* File: testbench/sbbs_top_tb.sv */
// Self-checking bench of the serial baud, break and status block.
// Assumes the line node model drives rx_pin; the bench drives all else.
`timescale 1ns/10ps

module sbbs_top_tb;
   logic                    core_clk = 1'b0;
   logic                    reset_n = 1'b0;
   logic [7:0]              reg_addr = 8'h00;
   logic [7:0]              reg_wdata = 8'h00;
   logic                    reg_wr = 1'b0;
   logic                    reg_rd = 1'b0;
   logic [7:0]              reg_rdata;
   logic                    serial_module_enable = 1'b1;
   logic                    char_len_sel = 1'b0;
   logic                    nine_bit_mode = 1'b0;
   logic                    rx_pin;
   sbbs_pkg::sbbs_rx_ev_s   rx_ev = '0;
   logic                    tx_break_req = 1'b0;
   logic                    tx_break_line, tx_break_done, tx_load, rt_tick, bit_tick, irq;
   sbbs_pkg::sbbs_brk_out_s brk_out;
   logic [7:0]              tx_byte;
   logic                    go = 1'b0;
   logic [11:0]             low_rt = 12'h000;
   logic                    node_busy;
   int                      err_total = 0;
   int                      num_checks = 0;
   int                      n_fe, n_full, n_nine, n_low, cyc;
   int                      bpd_tab [4] = '{1, 3, 4, 13};
   logic [31:0]             brk_tab [8] = '{32'h0020a401, 32'h00009c00, 32'h0010ac00,
      32'h4000ac00, 32'h4000b401, 32'h4010bc00, 32'h4010c401, 32'h00019001};
   logic [12:0]             baud_tab [7] = '{13'h0005, 13'h0800, 13'h1100, 13'h1a00,
      13'h0023, 13'h00ff, 13'h0700};

   sbbs_top i_dut (.core_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .serial_module_enable, .char_len_sel, .nine_bit_mode, .rx_pin, .rx_ev, .tx_break_req,
      .tx_break_line, .tx_break_done, .brk_out, .tx_byte, .tx_load, .rt_tick, .bit_tick, .irq);
   sbbs_line_node i_node (.core_clk, .rt_tick, .go, .low_rt, .rx_pin, .busy(node_busy));

   initial
   begin
      forever #2 core_clk = ~core_clk;
   end

   // ***************************************************************
   // Event counters and timeout
   // ***************************************************************
   always @(posedge core_clk)
   begin
      cyc++;
      n_fe += brk_out.framing_set;
      n_full += brk_out.full_set;
      n_nine += brk_out.ninth_clear;
      n_low += (bit_tick && !tx_break_line);
      if (cyc == 60000)
      begin
         err_total++;
         finish_test();
      end
   end

   task automatic finish_test;
      $display("checks=%0d errors=%0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : finish_test

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : wr_reg

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, e);
   endtask : rd_chk

   task automatic pev(input logic [11:0] v);
      @(posedge core_clk);
      rx_ev <= v;
      @(posedge core_clk);
      rx_ev <= '0;
   endtask : pev

   task automatic reset_dut;
      reset_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      reset_n <= 1'b1;
      @(posedge core_clk);
   endtask : reset_dut

   task automatic brk_row(input logic [31:0] r);
      int w = 0;
      wr_reg(8'h19, r[31:24]);
      nine_bit_mode <= r[21];
      char_len_sel <= r[20];
      n_fe = 0;
      n_full = 0;
      n_nine = 0;
      low_rt <= r[19:8];
      go <= 1'b1;
      @(posedge core_clk);
      go <= 1'b0;
      do @(posedge core_clk); while (node_busy && w++ < 9000);
      repeat (16) @(posedge core_clk);
      chk(16'(node_busy), 16'h0000);
      chk(16'(n_fe), r[0]);
      chk(16'(n_full), r[0]);
      chk(16'(n_nine), r[0] & r[21]);
      #1 chk(irq, 1'b0);
   endtask : brk_row

   task automatic send(input logic lin, input logic cl);
      int w = 0;
      wr_reg(8'h19, {lin, 7'h00});
      char_len_sel <= cl;
      n_low = 0;
      tx_break_req <= 1'b1;
      @(posedge core_clk);
      tx_break_req <= 1'b0;
      while (tx_break_done !== 1'b1 && w++ < 4000)
         @(posedge core_clk);
      repeat (2) @(posedge core_clk);
      chk(16'(n_low), (lin ? 16'h000d : 16'h000a) + cl);
      chk(tx_break_line, 1'b1);
      #1 chk(irq, 1'b1);
      wr_reg(8'h1b, 8'h02);
      #1 chk(irq, 1'b0);
   endtask : send

   task automatic baud(input logic [12:0] s);
      int c = 0;
      int k = 0;
      int e;
      e = bpd_tab[s[12:11]] * (1 << s[10:8]);
      e = e * ((s[7:5] == 3'h0) ? 32 : 32 * (int'(s[7:5]) + 1) + int'(s[4:0]));
      @(posedge core_clk);
      serial_module_enable <= 1'b0;
      wr_reg(8'h19, {2'b00, s[12:11], 1'b0, s[10:8]});
      wr_reg(8'h1a, s[7:0]);
      serial_module_enable <= 1'b1;
      do @(posedge core_clk); while (rt_tick !== 1'b1 && c++ < 5000);
      c = 0;
      while (k < 8 && c < 20000)
      begin
         @(posedge core_clk);
         c++;
         k += rt_tick;
      end
      chk(16'(c), 16'(e));
   endtask : baud

   // ***************************************************************
   // Main sequence
   // ***************************************************************
   initial
   begin
      reset_dut();
      pev(12'h1a5);
      rd_chk(8'h18, 8'ha5);
      wr_reg(8'h18, 8'h3c);
      #1 chk({tx_load, tx_byte}, 9'h13c);
      rd_chk(8'h18, 8'ha5);
      pev(12'h800);
      rd_chk(8'h16, 8'h01);
      pev(12'h400);
      rd_chk(8'h16, 8'h00);
      pev(12'h800);
      pev(12'h200);
      rd_chk(8'h16, 8'h00);
      wr_reg(8'h1b, 8'h07);
      wr_reg(8'h1c, 8'h01);
      #1 chk(irq, 1'b0);
      pev(12'h1a5);
      #1 chk(irq, 1'b1);
      wr_reg(8'h1c, 8'h00);
      #1 chk(irq, 1'b0);
      wr_reg(8'h1c, 8'hff);
      #1 chk(irq, 1'b1);
      wr_reg(8'h1b, 8'h01);
      #1 chk(irq, 1'b0);
      wr_reg(8'h19, 8'hff);
      serial_module_enable <= 1'b0;
      wr_reg(8'h1a, 8'hff);
      serial_module_enable <= 1'b1;
      rd_chk(8'h19, 8'hf7);
      rd_chk(8'h1a, 8'hff);
      rd_chk(8'h1c, 8'h07);
      rd_chk(8'h30, 8'h00);
      @(posedge core_clk);
      reset_dut();
      rd_chk(8'h19, 8'h00);
      rd_chk(8'h1a, 8'h00);
      rd_chk(8'h18, 8'ha5);
      rd_chk(8'h16, 8'h00);
      wr_reg(8'h1c, 8'h07);
      foreach (brk_tab[i])
         brk_row(brk_tab[i]);
      rd_chk(8'h18, 8'ha5);
      rd_chk(8'h16, 8'h02);
      rd_chk(8'h18, 8'ha5);
      rd_chk(8'h16, 8'h00);
      for (int i = 0; i < 4; i++)
         send(i[1], i[0]);
      foreach (baud_tab[i])
         baud(baud_tab[i]);
      finish_test();
   end
endmodule : sbbs_top_tb
